// [inc/spe_pkg.sv]
package spe_pkg;
    // ---------------------------------------------
    // program space map
    // ---------------------------------------------
    localparam logic [23:0] SPACE_TOP    = 24'hFFFFFE;
    localparam logic [23:0] CODE_BASE    = 24'h000000;
    localparam logic [23:0] CODE_END_4K  = 24'h001FFE;
    localparam logic [23:0] CODE_END_8K  = 24'h003FFE;
    localparam logic [23:0] CODE_END_16K = 24'h007FFE;
    localparam logic [23:0] CODE_END_22K = 24'h00AFFE;
    localparam logic [23:0] CODE_END_44K = 24'h015FFE;
    localparam logic [23:0] CODE_END_48K = 24'h017FFE;
    localparam int          MAX_CODE_WORDS = 49152;
    localparam logic [23:0] CODE_END     = CODE_END_4K;
    localparam logic [23:0] EE_BASE_1K   = 24'h7FFC00;
    localparam logic [23:0] EE_BASE_2K   = 24'h7FF800;
    localparam logic [23:0] EE_BASE_4K   = 24'h7FF000;
    localparam logic [23:0] EE_BASE      = EE_BASE_1K;
    localparam logic [23:0] EE_TOP       = 24'h7FFFFE;
    localparam logic [23:0] EXEC_BASE    = 24'h800000;
    localparam logic [23:0] EXEC_TOP     = 24'h8005BE;
    localparam logic [23:0] APPID_ADDR   = 24'h8005BE;
    localparam logic [23:0] CFG_BASE     = 24'hF80000;
    localparam logic [23:0] CFG_TOP      = 24'hF8000E;
    localparam logic [23:0] PART_ID_ADDR = 24'hFF0000;
    localparam logic [23:0] PART_REV_ADDR = 24'hFF0002;
    // ---------------------------------------------
    // storage shape
    // ---------------------------------------------
    localparam logic [11:0] CODE_LAST    = 12'hFFF;
    localparam logic [11:0] EE_LAST      = 12'h1FF;
    localparam logic [11:0] CODE_ROW_M   = 12'h01F;
    localparam logic [11:0] EE_ROW_M     = 12'h00F;
    localparam logic [2:0]  CFG_CP_IDX   = 3'h5;
    localparam logic [15:0] CFG_CP_MASK  = 16'h00FF;
    localparam logic [15:0] CFG_RESET    = 16'hFFFF;
    localparam logic [23:0] CODE_BLANK   = 24'hFFFFFF;
    localparam logic [15:0] EE_BLANK     = 16'hFFFF;
    // ---------------------------------------------
    // link frame and commands
    // ---------------------------------------------
    localparam logic [5:0]  FRAME_LAST   = 6'h37;
    localparam logic [5:0]  RESP_LAST    = 6'h18;
    localparam logic [3:0]  OP_READ      = 4'h1;
    localparam logic [3:0]  OP_BULK_ERASE = 4'h2;
    localparam logic [3:0]  OP_ROW_ERASE = 4'h3;
    localparam logic [3:0]  OP_PROG      = 4'h4;
    localparam logic [3:0]  OP_BLANK_Q   = 4'h5;
    localparam logic [3:0]  OP_VERSION_Q = 4'h6;
    localparam logic [3:0]  OP_CFG_PROG  = 4'h7;
    localparam logic [3:0]  MS_CODE      = 4'h1;
    localparam logic [3:0]  MS_EE        = 4'h2;
    localparam logic [3:0]  MS_CHIP      = 4'h3;
    localparam logic [23:0] RESP_OK      = 24'h000001;
    localparam logic [23:0] RESP_BLANK   = 24'h000010;
    localparam logic [23:0] RESP_NBLANK  = 24'h000011;
    localparam logic [23:0] RESP_ERR     = 24'h0000EE;

    typedef enum logic [2:0] {RG_NONE, RG_CODE, RG_EE, RG_CFG, RG_ID, RG_EXEC} spe_region_e;
    typedef enum logic [1:0] {LS_RX, LS_WAIT, LS_TX} spe_lstate_e;
    typedef enum logic [2:0] {CS_OFF, CS_IDLE, CS_RUN, CS_LOOP, CS_ANS} spe_cstate_e;

    typedef struct packed {
        logic [3:0]  op;
        logic [3:0]  ms;
        logic [23:0] addr;
        logic [23:0] data;
    } spe_frame_s;

    typedef struct packed {
        spe_lstate_e st;
        logic [5:0]  cnt;
        logic [55:0] shreg;
        spe_frame_s  frame;
        logic        ftog;
        logic [1:0]  msync;
        logic [1:0]  rsync;
        logic        rack;
        logic [24:0] tx;
        logic        dout;
        logic        doe;
    } spe_link_s;

    typedef struct packed {
        spe_cstate_e st;
        logic [1:0]  en_q;
        logic [1:0]  ck_q;
        logic [1:0]  dt_q;
        logic        en_d;
        logic [2:0]  ftq;
        logic        mode;
        logic        hiz;
        logic        sdo;
        spe_frame_s  cmd;
        logic [11:0] idx;
        logic [11:0] last;
        logic        wcode;
        logic        wee;
        logic        blk;
        logic        nb;
        logic [23:0] resp;
        logic        rtog;
    } spe_core_s;
endpackage

// [src/spe_exec_core.sv]
module spe_exec_core
    import spe_pkg::*;
#(
    parameter logic [15:0] PART_ID   = 16'h1234, // arbitrary value
    parameter logic [15:0] PART_REV  = 16'h0001, // arbitrary value
    parameter logic [23:0] APP_ID    = 24'h00005A, // arbitrary value
    parameter logic [23:0] EXEC_VER  = 24'h000100
) (
    // core clock and reset
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    // programming pins
    input  wire logic prog_serial_clock_pin_i,
    input  wire logic programming_enable_pin_i,
    input  wire logic prog_serial_data_pin_i,
    output logic      prog_serial_data_pin_o,
    output logic      prog_serial_data_pin_oe_o,
    // device side effects
    output logic      enh_mode_o,
    output logic      io_hiz_o,
    output logic      serial_periph_data_out_pin_o
);
    spe_link_s   lr, ln;
    spe_core_s   cr, cn;
    logic [23:0] code_mem [0:4095];
    logic [15:0] ee_mem   [0:511];
    logic [15:0] cfg_mem  [0:7];
    logic        code_we, ee_we, cfg_we, cp_set;
    logic [11:0] code_a;
    logic [8:0]  ee_a;
    logic [23:0] code_wd;
    logic [15:0] ee_wd;
    logic [23:0] code_rd;
    logic [15:0] ee_rd;
    logic        cp_on;
    logic        nbv;
    spe_region_e rg;

    // ---------------------------------------------
    // address decode
    // ---------------------------------------------
    function automatic spe_region_e region_of(input logic [23:0] a);
        if (a[0] || a > SPACE_TOP) return RG_NONE;
        if (a <= CODE_END) return RG_CODE;
        if (a >= EE_BASE && a <= EE_TOP) return RG_EE;
        if (a >= EXEC_BASE && a <= EXEC_TOP) return RG_EXEC;
        if (a >= CFG_BASE && a <= CFG_TOP) return RG_CFG;
        if (a == PART_ID_ADDR || a == PART_REV_ADDR) return RG_ID;
        return RG_NONE;
    endfunction

    // ---------------------------------------------
    // link side, on the host clock
    // ---------------------------------------------
    always_comb begin
        ln = lr;
        ln.msync = {lr.msync[0], cr.mode};
        ln.rsync = {lr.rsync[0], cr.rtog};
        unique case (lr.st)
            LS_RX: begin
                ln.shreg = {lr.shreg[54:0], prog_serial_data_pin_i};
                ln.cnt = lr.cnt + 6'h01;
                if (lr.cnt == FRAME_LAST) begin
                    ln.frame = {lr.shreg[54:0], prog_serial_data_pin_i};
                    ln.ftog = ~lr.ftog;
                    ln.st = LS_WAIT;
                    ln.cnt = '0;
                    ln.dout = 1'b0;
                    ln.doe = 1'b1;
                end
            end
            LS_WAIT: begin
                if (lr.rsync[1] != lr.rack) begin
                    ln.rack = lr.rsync[1];
                    ln.tx = {1'b1, cr.resp};
                    ln.st = LS_TX;
                end
            end
            LS_TX: begin
                ln.dout = lr.tx[24];
                ln.tx = {lr.tx[23:0], 1'b0};
                ln.cnt = lr.cnt + 6'h01;
                if (lr.cnt == RESP_LAST) begin
                    ln.st = LS_RX;
                    ln.cnt = '0;
                end
            end
        endcase
        // turnaround edge after an answer: release the pin, take no bit
        if (lr.st == LS_RX && lr.doe) begin
            ln.shreg = lr.shreg;
            ln.cnt = lr.cnt;
            ln.doe = 1'b0;
        end
        if (!lr.msync[1]) begin
            ln.st = LS_RX;
            ln.cnt = '0;
            ln.doe = 1'b0;
            ln.dout = 1'b0;
        end
    end

    always_ff @(posedge prog_serial_clock_pin_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lr <= '0;
        end else begin
            lr <= ln;
        end
    end

    // ---------------------------------------------
    // storage reads
    // ---------------------------------------------
    always_comb begin
        code_a = (cr.st == CS_LOOP) ? cr.idx : cr.cmd.addr[12:1];
        ee_a = (cr.st == CS_LOOP) ? cr.idx[8:0] : cr.cmd.addr[9:1];
        code_rd = code_mem[code_a];
        ee_rd = ee_mem[ee_a];
        cp_on = (cfg_mem[CFG_CP_IDX] & CFG_CP_MASK) != CFG_CP_MASK;
        rg = region_of(cr.cmd.addr);
        nbv = cr.nb | (code_rd != CODE_BLANK)
            | ((cr.idx <= EE_LAST) && (ee_rd != EE_BLANK));
    end

    // ---------------------------------------------
    // executive, on the core clock
    // ---------------------------------------------
    always_comb begin
        cn = cr;
        code_we = 1'b0;
        ee_we = 1'b0;
        cfg_we = 1'b0;
        cp_set = 1'b0;
        code_wd = cr.cmd.data;
        ee_wd = cr.cmd.data[15:0];
        cn.en_q = {cr.en_q[0], programming_enable_pin_i};
        cn.ck_q = {cr.ck_q[0], prog_serial_clock_pin_i};
        cn.dt_q = {cr.dt_q[0], prog_serial_data_pin_i};
        cn.en_d = cr.en_q[1];
        cn.ftq = {cr.ftq[1:0], lr.ftog};
        cn.sdo = (cr.st == CS_LOOP) ? ~cr.sdo : 1'b0;
        unique case (cr.st)
            CS_OFF: begin
                cn.st = CS_OFF;
            end
            CS_IDLE: begin
                if (cr.ftq[2] != cr.ftq[1]) begin
                    cn.cmd = lr.frame;
                    cn.st = CS_RUN;
                end
            end
            CS_RUN: begin
                cn.resp = RESP_ERR;
                cn.st = CS_ANS;
                cn.blk = 1'b0;
                cn.nb = 1'b0;
                cn.wcode = 1'b0;
                cn.wee = 1'b0;
                cn.idx = '0;
                cn.last = CODE_LAST;
                unique case (cr.cmd.op)
                    OP_READ: begin
                        unique case (rg)
                            RG_CODE: cn.resp = cp_on ? '0 : code_rd;
                            RG_EE:   cn.resp = cp_on ? '0 : {8'h00, ee_rd};
                            RG_CFG:  cn.resp = {8'h00, cfg_mem[cr.cmd.addr[3:1]]};
                            RG_ID:   cn.resp = {8'h00, cr.cmd.addr[1] ? PART_REV
                                                                      : PART_ID};
                            RG_EXEC: cn.resp = (cr.cmd.addr == APPID_ADDR) ? APP_ID
                                                                          : '0;
                            default: cn.resp = RESP_ERR;
                        endcase
                    end
                    OP_PROG: begin
                        code_we = (rg == RG_CODE);
                        ee_we = (rg == RG_EE);
                        if (rg == RG_CODE || rg == RG_EE) cn.resp = RESP_OK;
                    end
                    OP_CFG_PROG: begin
                        cfg_we = (rg == RG_CFG);
                        if (rg == RG_CFG) cn.resp = RESP_OK;
                    end
                    OP_BULK_ERASE: begin
                        cn.wcode = (cr.cmd.ms == MS_CODE) || (cr.cmd.ms == MS_CHIP);
                        cn.wee = (cr.cmd.ms == MS_EE) || (cr.cmd.ms == MS_CHIP);
                        cp_set = (cr.cmd.ms == MS_CHIP);
                        if (cn.wcode || cn.wee) cn.st = CS_LOOP;
                    end
                    OP_ROW_ERASE: begin
                        if (rg == RG_CODE) begin
                            cn.idx = cr.cmd.addr[12:1] & ~CODE_ROW_M;
                            cn.last = cr.cmd.addr[12:1] | CODE_ROW_M;
                            cn.wcode = 1'b1;
                            cn.st = CS_LOOP;
                        end else if (rg == RG_EE) begin
                            cn.idx = {3'h0, cr.cmd.addr[9:1]} & ~EE_ROW_M;
                            cn.last = {3'h0, cr.cmd.addr[9:1]} | EE_ROW_M;
                            cn.wee = 1'b1;
                            cn.st = CS_LOOP;
                        end
                    end
                    OP_BLANK_Q: begin
                        cn.blk = 1'b1;
                        cn.st = CS_LOOP;
                    end
                    OP_VERSION_Q: cn.resp = EXEC_VER;
                    default: cn.resp = RESP_ERR;
                endcase
            end
            CS_LOOP: begin
                code_wd = CODE_BLANK;
                ee_wd = EE_BLANK;
                code_we = cr.wcode;
                ee_we = cr.wee && (cr.idx <= EE_LAST);
                if (cr.blk) cn.nb = nbv;
                cn.idx = cr.idx + 12'h001;
                if (cr.idx == cr.last) begin
                    cn.st = CS_ANS;
                    cn.resp = !cr.blk ? RESP_OK : (nbv ? RESP_NBLANK : RESP_BLANK);
                end
            end
            CS_ANS: begin
                cn.rtog = ~cr.rtog;
                cn.st = CS_IDLE;
            end
        endcase
        if (cr.en_q[1] && !cr.en_d && cr.ck_q[1] && cr.dt_q[1]) begin
            cn.mode = 1'b1;
            cn.hiz = 1'b1;
            cn.st = CS_IDLE;
        end
        if (!cr.en_q[1]) begin
            cn.mode = 1'b0;
            cn.hiz = 1'b0;
            cn.st = CS_OFF;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cr <= '0;
        end else begin
            cr <= cn;
        end
    end

    // ---------------------------------------------
    // storage writes
    // ---------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (code_we) code_mem[code_a] <= code_wd;
        if (ee_we) ee_mem[ee_a] <= ee_wd;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < 8; i++) cfg_mem[i] <= CFG_RESET;
        end else if (cfg_we) begin
            cfg_mem[cr.cmd.addr[3:1]] <= cr.cmd.data[15:0];
        end else if (cp_set) begin
            cfg_mem[CFG_CP_IDX] <= cfg_mem[CFG_CP_IDX] | CFG_CP_MASK;
        end
    end

    assign prog_serial_data_pin_o = lr.dout;
    assign prog_serial_data_pin_oe_o = lr.doe;
    assign enh_mode_o = cr.mode;
    assign io_hiz_o = cr.hiz;
    assign serial_periph_data_out_pin_o = cr.sdo;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    property p_entry;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cr.en_q[1] && !cr.en_d && cr.ck_q[1] && cr.dt_q[1]) |=> enh_mode_o && io_hiz_o;
    endproperty
    a_entry: assert property (p_entry) else $error("mode entry missed");

    property p_hiz;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        enh_mode_o |-> io_hiz_o;
    endproperty
    a_hiz: assert property (p_hiz) else $error("pins not floated");

    property p_sdo;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cr.st == CS_LOOP) ##1 (cr.st == CS_LOOP) |->
            serial_periph_data_out_pin_o != $past(serial_periph_data_out_pin_o);
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo not toggling");

    property p_erase_ones;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cr.st == CS_LOOP && !cr.blk) |-> code_wd == CODE_BLANK && ee_wd == EE_BLANK;
    endproperty
    a_erase_ones: assert property (p_erase_ones) else $error("erase not ones");

    property p_id;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cr.st == CS_RUN && cr.cmd.op == OP_READ && cr.cmd.addr == PART_ID_ADDR)
            |=> cr.resp[15:0] == PART_ID ##1 cr.st == CS_IDLE;
    endproperty
    a_id: assert property (p_id) else $error("id word wrong");

    property p_exec_ro;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cr.st == CS_RUN && region_of(cr.cmd.addr) == RG_EXEC) |-> !code_we && !ee_we;
    endproperty
    a_exec_ro: assert property (p_exec_ro) else $error("exec region written");

    property p_odd;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cr.st == CS_RUN && cr.cmd.op == OP_READ && cr.cmd.addr[0]) |=> cr.resp == RESP_ERR;
    endproperty
    a_odd: assert property (p_odd) else $error("odd address decoded");

    property p_blank;
        @(posedge core_clk_i) disable iff (!reset_n_i)
        (cr.st == CS_LOOP && cr.blk && cr.idx == cr.last) |=>
            (cr.resp == RESP_BLANK || cr.resp == RESP_NBLANK) ##1 cr.rtog != $past(cr.rtog);
    endproperty
    a_blank: assert property (p_blank) else $error("blank answer wrong");

    property p_busy;
        @(posedge prog_serial_clock_pin_i) disable iff (!reset_n_i)
        (lr.st == LS_WAIT && lr.msync[1]) |-> prog_serial_data_pin_oe_o
            && !prog_serial_data_pin_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not driven");
endmodule

// [dv/spe_host_model.sv]
// ----------------------------------------
// programmer host: entry, frames, answers
// ----------------------------------------
module spe_host_model
    import spe_pkg::*;
(
    // core clock for entry pacing
    input  wire logic core_clk_i,
    // programming pins
    input  wire logic prog_serial_data_pin_i,
    output logic      prog_serial_clock_pin_o,
    output logic      programming_enable_pin_o,
    output logic      prog_serial_data_pin_o,
    output logic      prog_serial_data_pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        prog_serial_clock_pin_o   = 1'b1;
        programming_enable_pin_o  = 1'b0;
        prog_serial_data_pin_o    = 1'b1;
        prog_serial_data_pin_oe_o = 1'b1;
    end

    // link clock runs inside these pulses and in xfer, idles high
    task automatic pulse(input int n);
        repeat (n) begin
            prog_serial_clock_pin_o = 1'b0;
            #80;
            prog_serial_clock_pin_o = 1'b1;
            #80;
        end
    endtask

    // clock and data set first, enable raised afterwards
    task automatic enter(input logic ck, input logic dt);
        prog_serial_clock_pin_o = ck;
        prog_serial_data_pin_o  = dt;
        repeat (10) @(negedge core_clk_i);
        programming_enable_pin_o = 1'b1;
        repeat (10) @(negedge core_clk_i);
        prog_serial_clock_pin_o = 1'b1;
        prog_serial_data_pin_o  = 1'b1;
        pulse(2);
    endtask

    task automatic leave();
        @(negedge core_clk_i);
        programming_enable_pin_o = 1'b0;
        repeat (10) @(negedge core_clk_i);
    endtask

    // one frame out msb first, then wait for the whole answer
    task automatic xfer(input spe_frame_s f, output logic [23:0] r, output logic ok);
        logic [55:0] sh;
        int          n;
        sh = f;
        r  = '0;                               // no ram state assumed
        ok = 1'b0;
        n  = 0;
        for (int i = 55; i >= 0; i--) begin
            prog_serial_clock_pin_o = 1'b0;
            prog_serial_data_pin_o  = sh[i];
            #80;
            prog_serial_clock_pin_o = 1'b1;
            #80;
        end
        prog_serial_data_pin_oe_o = 1'b0;
        while (n < 300 && !ok) begin
            prog_serial_clock_pin_o = 1'b0;
            ok = (prog_serial_data_pin_i === 1'b1);
            #80;
            prog_serial_clock_pin_o = 1'b1;
            #80;
            n++;
        end
        if (ok) begin
            for (int i = 23; i >= 0; i--) begin
                prog_serial_clock_pin_o = 1'b0;
                r[i] = prog_serial_data_pin_i;
                #80;
                prog_serial_clock_pin_o = 1'b1;
                #80;
            end
        end
        prog_serial_data_pin_o    = 1'b1;
        prog_serial_data_pin_oe_o = 1'b1;
    endtask
endmodule

// [dv/test_serial_programming_executive.sv]
module test_serial_programming_executive
    import spe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // identity values, all arbitrary
    // ----------------------------------------
    localparam logic [15:0] PID_V = 16'h4D21;
    localparam logic [15:0] REV_V = 16'h0007;
    localparam logic [23:0] AID_V = 24'h00003C;
    localparam logic [23:0] VER_V = 24'h000203;

    logic core_clk;
    logic reset_n;
    logic lclk;
    logic en;
    logic hd;
    logic hoe;
    logic dd;
    logic doe;
    logic enh;
    logic hiz;
    logic sdo;
    logic pin_last;
    logic sdo_q;
    wire  pin = doe ? dd : (hoe ? hd : ~pin_last);
    int   err_count;
    int   checked;
    int   sdo_flips;

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        pin_last <= pin;
    end

    // sdo moves on the rising edge, so it is counted on the falling one
    always @(negedge core_clk) begin
        sdo_q <= sdo;
        if (sdo !== sdo_q) sdo_flips++;
    end

    spe_exec_core #(
        .PART_ID  (PID_V),
        .PART_REV (REV_V),
        .APP_ID   (AID_V),
        .EXEC_VER (VER_V)
    ) u_spe_exec_core (
        .core_clk_i                   (core_clk),
        .reset_n_i                    (reset_n),
        .prog_serial_clock_pin_i      (lclk),
        .programming_enable_pin_i     (en),
        .prog_serial_data_pin_i       (pin),
        .prog_serial_data_pin_o       (dd),
        .prog_serial_data_pin_oe_o    (doe),
        .enh_mode_o                   (enh),
        .io_hiz_o                     (hiz),
        .serial_periph_data_out_pin_o (sdo)
    );

    spe_host_model u_spe_host_model (
        .core_clk_i                (core_clk),
        .prog_serial_data_pin_i    (pin),
        .prog_serial_clock_pin_o   (lclk),
        .programming_enable_pin_o  (en),
        .prog_serial_data_pin_o    (hd),
        .prog_serial_data_pin_oe_o (hoe)
    );

    // ----------------------------------------
    // compare and report
    // ----------------------------------------
    task automatic end_sim();
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: answer %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s is %b", $time, what, got);
        end
    endtask

    task automatic cmd(input logic [3:0] op, input logic [3:0] ms, input logic [23:0] a,
                       input logic [23:0] d, input logic [23:0] exp);
        logic [23:0] r;
        logic        ok;
        u_spe_host_model.xfer('{op: op, ms: ms, addr: a, data: d}, r, ok);
        if (!ok) begin
            err_count++;
            $display("unexpected at %0t: no answer", $time);
            end_sim();
        end else begin
            chk_val(r, exp);
            chk_bit(doe, 1'b0, "data enable after answer");
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        err_count = 0;
        checked   = 0;
        sdo_flips = 0;
        reset_n   = 1'b0;
        pin_last  = 1'b1;
        u_spe_host_model.pulse(2);
        repeat (12) @(negedge core_clk);
        reset_n = 1'b1;
        repeat (4) @(negedge core_clk);
        chk_bit(enh, 1'b0, "mode after reset");
        u_spe_host_model.enter(1'b0, 1'b1);
        chk_bit(enh, 1'b0, "mode with clock low");
        u_spe_host_model.leave();
        u_spe_host_model.enter(1'b1, 1'b1);
        chk_bit(enh, 1'b1, "mode after entry");
        chk_bit(hiz, 1'b1, "io float after entry");
        cmd(OP_READ, 4'h0, APPID_ADDR, 24'h0, AID_V);
        cmd(OP_CFG_PROG, 4'h0, CFG_BASE + 24'h00000A, 24'h00FF00, RESP_OK);
        cmd(OP_READ, 4'h0, PART_ID_ADDR, 24'h0, {8'h00, PID_V});
        cmd(OP_READ, 4'h0, PART_REV_ADDR, 24'h0, {8'h00, REV_V});
        cmd(OP_READ, 4'h0, 24'h000001, 24'h0, RESP_ERR);
        cmd(OP_VERSION_Q, 4'h0, 24'h0, 24'h0, VER_V);
        sdo_flips = 0;
        cmd(OP_BULK_ERASE, MS_CHIP, 24'h0, 24'h0, RESP_OK);
        chk_bit(sdo_flips > 1, 1'b1, "peripheral output toggling");
        cmd(OP_BLANK_Q, 4'h0, 24'h0, 24'h0, RESP_BLANK);
        cmd(OP_READ, 4'h0, CODE_BASE, 24'h0, CODE_BLANK);
        cmd(OP_READ, 4'h0, CODE_END, 24'h0, CODE_BLANK);
        cmd(OP_READ, 4'h0, EE_BASE, 24'h0, {8'h00, EE_BLANK});
        cmd(OP_READ, 4'h0, CFG_BASE + 24'h00000A, 24'h0, 24'h00FFFF);
        cmd(OP_READ, 4'h0, CFG_TOP, 24'h0, {8'h00, CFG_RESET});
        cmd(OP_READ, 4'h0, PART_ID_ADDR, 24'h0, {8'h00, PID_V});
        cmd(OP_PROG, MS_CODE, 24'h000010, 24'h123456, RESP_OK);
        cmd(OP_READ, 4'h0, 24'h000010, 24'h0, 24'h123456);
        cmd(OP_BLANK_Q, 4'h0, 24'h0, 24'h0, RESP_NBLANK);
        cmd(OP_ROW_ERASE, MS_CODE, 24'h000010, 24'h0, RESP_OK);
        cmd(OP_READ, 4'h0, 24'h000010, 24'h0, CODE_BLANK);
        cmd(OP_PROG, MS_EE, EE_TOP, 24'h00ABCD, RESP_OK);
        cmd(OP_READ, 4'h0, EE_TOP, 24'h0, 24'h00ABCD);
        cmd(OP_PROG, MS_CODE, EXEC_BASE, 24'h111111, RESP_ERR);
        cmd(OP_CFG_PROG, 4'h0, CFG_BASE, 24'h00FFFF, RESP_OK);
        chk_bit(sdo, 1'b0, "peripheral output idle");
        u_spe_host_model.leave();
        chk_bit(enh, 1'b0, "mode after enable low");
        chk_bit(hiz, 1'b0, "io float after exit");
        end_sim();
    end
endmodule
